// ### ddr3_reset_init_sequence_tb_top.sv
// self-checking bench for the DDR3 reset and initialization tracker
`timescale 1ns/1ps
module ddr3_reset_init_sequence_tb_top;
  logic sys_clk, nrst, psel, penable, pwrite, start, swap, rd_active, rd_strobe, e, odt_hi;
  logic [7:0] paddr, rst_cyc;
  logic [31:0] pwdata, prdata, d;
  logic [13:0] mr1, mem_addr;
  logic [2:0] mem_ba;
  logic pready, pslverr, done, mem_reset_n, mem_cke, mem_odt, mem_cs_n, mem_ras_n;
  logic mem_cas_n, mem_we_n, dqsl_o, dqsl_n_o, dqsl_oe, dqsu_o, dqsu_n_o, dqsu_oe;
  logic odt_term_en, tdqs_term_en, dm_en, init_done;
  int n_errors = 0;
  int checks = 0;
  always #5 sys_clk = ~sys_clk;
  dri_top #(.INIT_CYC(20), .TXS_CYC(5), .DLLK_CYC(16), .ZQINIT_CYC(16)) dri_top_inst (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_reset_n(mem_reset_n), .mem_cke(mem_cke), .mem_odt(mem_odt), .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba),
    .mem_addr(mem_addr), .rd_active(rd_active), .rd_strobe(rd_strobe), .dqsl_o(dqsl_o),
    .dqsl_n_o(dqsl_n_o), .dqsl_oe(dqsl_oe), .dqsu_o(dqsu_o), .dqsu_n_o(dqsu_n_o),
    .dqsu_oe(dqsu_oe), .odt_term_en(odt_term_en), .tdqs_term_en(tdqs_term_en),
    .dm_en(dm_en), .init_done(init_done));
  dri_ctrl_model dri_ctrl_model_inst (.sys_clk(sys_clk), .start(start), .rst_cyc(rst_cyc),
    .mr1(mr1), .swap(swap), .odt_hi(odt_hi),
    .done(done), .mem_reset_n(mem_reset_n), .mem_cke(mem_cke),
    .mem_odt(mem_odt), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n), .mem_cas_n(mem_cas_n),
    .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr));
  task automatic close_out;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      close_out;
    end
    @(posedge sys_clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m);
    apb(1'b0, a, 32'h00000000);
    chk(nm, exp, d & m);
  endtask
  // one full controller sequence, then wait for the model to finish
  task automatic run(input logic [7:0] rc, input logic [13:0] m1, input logic sw);
    int n;
    rst_cyc <= rc;
    mr1 <= m1;
    swap <= sw;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 1000) begin
      n_errors++;
      close_out;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, start, swap, rd_active, rd_strobe} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rst_cyc = 8'h1E;
    mr1 = 14'h0000;
    odt_hi = 1'b1;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk("dm_en", 32'h1, dm_en);
    rdc("ctrl", 8'h00, 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped data", 32'h0, d);
    chk("unmapped err", 32'h1, e);
    run(8'h1E, 14'h0800, 1'b0);
    chk("init_done", 32'h1, init_done);
    rdc("status", 8'h04, 32'h1E, 32'h3F);
    rdc("err", 8'h08, 32'h0, 32'hFFF);
    rdc("mr0", 8'h10, 32'h100, 32'hFFFFFFFF);
    rdc("mr1", 8'h14, 32'h800, 32'hFFFFFFFF);
    chk("tdqs_term_en", 32'h1, tdqs_term_en);
    chk("dm_en", 32'h0, dm_en);
    chk("odt rtt off", 32'h0, odt_term_en);
    rd_active <= 1'b1;
    rd_strobe <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("dqsl", 32'h5, {dqsl_o, dqsl_n_o, dqsl_oe});
    chk("dqsu_oe x8", 32'h0, dqsu_oe);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk("dqsu", 32'h5, {dqsu_o, dqsu_n_o, dqsu_oe});
    chk("tdqs x16", 32'h0, tdqs_term_en);
    rd_active <= 1'b0;
    run(8'h0A, 14'h0844, 1'b0);
    rdc("err x16", 8'h08, 32'h400, 32'h401);
    chk("odt rtt on", 32'h1, odt_term_en);
    apb(1'b1, 8'h08, 32'h00000FFF);
    rdc("err clear", 8'h08, 32'h0, 32'hFFF);
    apb(1'b1, 8'h00, 32'h0);
    odt_hi <= 1'b0;
    run(8'h05, 14'h0000, 1'b1);
    rdc("err bad", 8'h08, 32'h81, 32'h81);
    chk("init_done bad", 32'h0, init_done);
    close_out;
  end
endmodule // ddr3_reset_init_sequence_tb_top

// ### dri_cmd_dec.v
// registers the memory pins and decodes the command on each rising edge
`timescale 1ns/1ps
`include "dri_regs.vh"
module dri_cmd_dec (
  input wire sys_clk,
  input wire nrst,
  input wire mem_reset_n,
  input wire mem_cke,
  input wire mem_odt,
  input wire mem_cs_n,
  input wire mem_ras_n,
  input wire mem_cas_n,
  input wire mem_we_n,
  input wire [2:0] mem_ba,
  input wire [13:0] mem_addr,
  output reg rst_n_q,
  output reg cke_q,
  output reg odt_q,
  output reg [2:0] cmd_q,
  output reg [2:0] ba_q,
  output reg [13:0] addr_q
);

  function [2:0] f_cmd;
    input cs_n;
    input [2:0] rcw;
    input a10;
    begin
      if (cs_n)
        f_cmd = `DRI_CMD_DES;
      else if (rcw == 3'h7)
        f_cmd = `DRI_CMD_NOP;
      else if (rcw == 3'h0)
        f_cmd = `DRI_CMD_MRS;
      else if (rcw == 3'h6 && a10)
        f_cmd = `DRI_CMD_ZQL;
      else
        f_cmd = `DRI_CMD_OTHER;
    end
  endfunction

  // every pin is taken on the rising edge only [R20]
  always @(posedge sys_clk) begin
    if (!nrst) begin
      rst_n_q <= 1'b0;
      cke_q <= 1'b0;
      odt_q <= 1'b0;
      cmd_q <= `DRI_CMD_DES;
      ba_q <= 3'h0;
      addr_q <= 14'h0000;
    end else begin
      rst_n_q <= mem_reset_n;
      cke_q <= mem_cke;
      odt_q <= mem_odt;
      cmd_q <= f_cmd(mem_cs_n, {mem_ras_n, mem_cas_n, mem_we_n}, mem_addr[10]);
      ba_q <= mem_ba;
      addr_q <= mem_addr;
    end
  end

endmodule // dri_cmd_dec

// ### dri_ctrl_model.sv
// behavioural memory-controller model driving the reset and init pins
`timescale 1ns/1ps
module dri_ctrl_model #(
  parameter int INIT_CYC = 20,
  parameter int XPR_CYC = 5,
  parameter int MRD_CYC = 4,
  parameter int MOD_CYC = 12,
  parameter int CAL_CYC = 16
) (
  input logic sys_clk,
  input logic start,
  input logic [7:0] rst_cyc,
  input logic [13:0] mr1,
  input logic swap,
  input logic odt_hi,
  output logic done,
  output logic mem_reset_n,
  output logic mem_cke,
  output logic mem_odt,
  output logic mem_cs_n,
  output logic mem_ras_n,
  output logic mem_cas_n,
  output logic mem_we_n,
  output logic [2:0] mem_ba,
  output logic [13:0] mem_addr
);
  // idle bank and address lines carry the inverse, never the last value
  task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic [13:0] a,
                       input int gap);
    {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= c;
    mem_ba <= ba;
    mem_addr <= a;
    @(posedge sys_clk);
    {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= 4'h7;
    mem_ba <= ~ba;
    mem_addr <= ~a;
    repeat (gap - 1) @(posedge sys_clk);
  endtask
  initial begin
    done = 1'b0;
    mem_reset_n = 1'b0;
    mem_cke = 1'b0;
    mem_odt = 1'b0;
    {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = 4'hF;
    mem_ba = 3'h0;
    mem_addr = 14'h0000;
    forever begin
      @(posedge sys_clk);
      if (start) begin
        done <= 1'b0;
        mem_cke <= 1'b0;
        mem_odt <= 1'b0;
        @(posedge sys_clk);
        mem_reset_n <= 1'b0;
        repeat (rst_cyc) @(posedge sys_clk);
        mem_reset_n <= 1'b1;
        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= 4'h7;
        repeat (INIT_CYC + 6) @(posedge sys_clk);
        mem_cke <= 1'b1;
        repeat (XPR_CYC + 2) @(posedge sys_clk);
        issue(4'h0, swap ? 3'h3 : 3'h2, 14'h0000, MRD_CYC + 1);
        issue(4'h0, swap ? 3'h2 : 3'h3, 14'h0000, MRD_CYC + 1);
        issue(4'h0, 3'h1, mr1, MRD_CYC + 1);
        issue(4'h0, 3'h0, 14'h0100, MOD_CYC + 1);
        issue(4'h6, 3'h0, 14'h0400, CAL_CYC + 4);
        done <= 1'b1;
      end else begin
        // termination may be switched on only once the sequence is over
        mem_odt <= done & odt_hi;
      end
    end
  end
endmodule // dri_ctrl_model

// ### dri_regs.vh
// constants for the DDR3 device-side reset and initialization tracker
// Notes on behaviour
// R01 - RESET# low means reset active; high is inactive and stays high in normal use.
// R02 - Controller holds RESET# low at least 200 us after power is stable; the tracker checks only DRI_CYC_RST cycles (100 ns).
// R03 - Controller drives CKE low at least 10 ns before releasing RESET#.
// R04 - Warm reset holds RESET# at least 100 ns, then repeats init steps 2 to 11.
// R05 - After RESET# release, 500 us internal init, clock-independent, before CKE rises.
// R06 - Clock runs stable for the longer of 10 ns or 5 clocks before CKE rises.
// R07 - A NOP or Deselect is registered on the edge before CKE first rises.
// R08 - Once registered high after reset, CKE stays high until initialization completes.
// R09 - Device keeps termination off during reset and until CKE is registered high; only odt_term_en is gated, tdqs_term_en ignores reset and CKE.
// R10 - ODT held static from CKE rise to init end; low if nominal termination enabled.
// R11 - First mode-register load waits tXPR, the larger of tXS and 5 clocks, after CKE.
// R12 - First load targets MR2 (BA=010), next MR3 (BA=011).
// R13 - Third load targets MR1 (BA=001) with DLL enabled, A0 low.
// R14 - Fourth load targets MR0 (BA=000) with DLL reset, A8 high.
// R15 - ZQ long calibration follows, then both DLL lock and calibration times elapse.
// R16 - On x8, MR1 A11 set gives strobe termination; clear gives data mask.
// R17 - On x16, the controller keeps MR1 A11 at 0.
// R18 - Strobe is differential only; device drives it edge-aligned with read data.
// R19 - On x16, lower strobe pair times lower byte, upper pair times upper byte.
// R20 - Address and command inputs are sampled on the rising clock edge.
// R21 - MRS spacing at least tMRD; other non-NOP commands wait tMOD after MRS; the tracker checks tMOD only for the ZQ long calibration command.
// R22 - Controller implements each timed wait as a cycle counter rounded up.
`ifndef DRI_REGS_VH
`define DRI_REGS_VH

`define DRI_CLK_PERIOD_NS 10
`define DRI_T_RST_MIN_NS 100
`define DRI_T_CKE_LOW_NS 10
`define DRI_T_INIT_US 500
`define DRI_XPR_MIN_TCK 5
`define DRI_CYC_RST ((`DRI_T_RST_MIN_NS + `DRI_CLK_PERIOD_NS - 1) / `DRI_CLK_PERIOD_NS)
`define DRI_CYC_CKE_LOW ((`DRI_T_CKE_LOW_NS + `DRI_CLK_PERIOD_NS - 1) / `DRI_CLK_PERIOD_NS)
`define DRI_CYC_INIT ((`DRI_T_INIT_US * 1000 + `DRI_CLK_PERIOD_NS - 1) / `DRI_CLK_PERIOD_NS)

`define DRI_OFF_CTRL 8'h00
`define DRI_OFF_STATUS 8'h04
`define DRI_OFF_ERR 8'h08
`define DRI_OFF_MR_BASE 4'h1
`define DRI_CTRL_RST 1'b0

`define DRI_CMD_DES 3'h0
`define DRI_CMD_NOP 3'h1
`define DRI_CMD_MRS 3'h2
`define DRI_CMD_ZQL 3'h3
`define DRI_CMD_OTHER 3'h4

`define DRI_BA_MR0 3'h0
`define DRI_BA_MR1 3'h1
`define DRI_BA_MR2 3'h2
`define DRI_BA_MR3 3'h3

`define DRI_MR1_DLL_DIS 0
`define DRI_MR1_TDQS 11
`define DRI_MR0_DLL_RST 8

`define DRI_ERR_W 12
`define DRI_ERR_SHORT_RST 0
`define DRI_ERR_CKE_NOT_LOW 1
`define DRI_ERR_EARLY_CKE 2
`define DRI_ERR_NO_NOP 3
`define DRI_ERR_CKE_DROP 4
`define DRI_ERR_ODT 5
`define DRI_ERR_TXPR 6
`define DRI_ERR_ORDER 7
`define DRI_ERR_TMRD 8
`define DRI_ERR_TMOD 9
`define DRI_ERR_X16_TDQS 10
`define DRI_ERR_DLL 11

`endif

// ### dri_top.v
// device-side DDR3 reset and initialization tracker with APB status registers
`timescale 1ns/1ps
`include "dri_regs.vh"
module dri_top #(
  parameter INIT_CYC = `DRI_CYC_INIT,
  parameter TXS_CYC = 16,
  parameter MRD_CYC = 4,
  parameter MOD_CYC = 12,
  parameter DLLK_CYC = 512,
  parameter ZQINIT_CYC = 512
) (
  input wire sys_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire mem_reset_n,
  input wire mem_cke,
  input wire mem_odt,
  input wire mem_cs_n,
  input wire mem_ras_n,
  input wire mem_cas_n,
  input wire mem_we_n,
  input wire [2:0] mem_ba,
  input wire [13:0] mem_addr,
  input wire rd_active,
  input wire rd_strobe,
  output reg dqsl_o,
  output reg dqsl_n_o,
  output reg dqsl_oe,
  output reg dqsu_o,
  output reg dqsu_n_o,
  output reg dqsu_oe,
  output reg odt_term_en,
  output reg tdqs_term_en,
  output reg dm_en,
  output reg init_done
);

  localparam [2:0] ST_RESET = 3'h0;
  localparam [2:0] ST_INTINIT = 3'h1;
  localparam [2:0] ST_WAIT_CKE = 3'h2;
  localparam [2:0] ST_MRS = 3'h3;
  localparam [2:0] ST_ZQ = 3'h4;
  localparam [2:0] ST_CAL = 3'h5;
  localparam [2:0] ST_READY = 3'h6;
  localparam XPR_CYC = (TXS_CYC > `DRI_XPR_MIN_TCK) ? TXS_CYC : `DRI_XPR_MIN_TCK;
  localparam CAL_CYC = (DLLK_CYC > ZQINIT_CYC) ? DLLK_CYC : ZQINIT_CYC;

  wire rst_r;
  wire cke_r;
  wire odt_r;
  wire [2:0] cmd_r;
  wire [2:0] ba_r;
  wire [13:0] addr_r;

  reg [2:0] state_q, state_d;
  reg [15:0] cnt_q, cnt_d;
  reg [1:0] step_q, step_d;
  reg [7:0] rst_len_q, rst_len_d;
  reg [7:0] cke_low_q;
  reg [7:0] mrs_gap_q;
  reg [2:0] last_cmd_q;
  reg cke_seen_q, cke_seen_d;
  reg odt_lock_q, odt_lock_d;
  reg [`DRI_ERR_W-1:0] err_q, err_set;
  reg mr_we;
  reg [13:0] mr_q [0:3];
  reg x16_q;
  wire rtt_nom_on;
  wire wr_acc;
  wire mapped;
  integer i;

  dri_cmd_dec u_dec (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .mem_reset_n(mem_reset_n),
    .mem_cke(mem_cke),
    .mem_odt(mem_odt),
    .mem_cs_n(mem_cs_n),
    .mem_ras_n(mem_ras_n),
    .mem_cas_n(mem_cas_n),
    .mem_we_n(mem_we_n),
    .mem_ba(mem_ba),
    .mem_addr(mem_addr),
    .rst_n_q(rst_r),
    .cke_q(cke_r),
    .odt_q(odt_r),
    .cmd_q(cmd_r),
    .ba_q(ba_r),
    .addr_q(addr_r)
  );

  function [7:0] f_sat8;
    input [7:0] v;
    begin
      f_sat8 = (v == 8'hFF) ? v : v + 8'h01;
    end
  endfunction

  // mode register expected at each step of the load sequence
  function [2:0] f_exp_ba;
    input [1:0] step;
    begin
      case (step)
        2'h0: f_exp_ba = `DRI_BA_MR2;
        2'h1: f_exp_ba = `DRI_BA_MR3;
        2'h2: f_exp_ba = `DRI_BA_MR1;
        default: f_exp_ba = `DRI_BA_MR0;
      endcase
    end
  endfunction

  assign rtt_nom_on = mr_q[1][9] | mr_q[1][6] | mr_q[1][2];

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    step_d = step_q;
    rst_len_d = rst_len_q;
    cke_seen_d = cke_seen_q;
    odt_lock_d = odt_lock_q;
    err_set = {`DRI_ERR_W{1'b0}};
    mr_we = 1'b0;
    if (!rst_r) begin
      // pin low is reset whatever the sequence had reached [R01]
      state_d = ST_RESET;
      cnt_d = 16'h0000;
      step_d = 2'h0;
      cke_seen_d = 1'b0;
      rst_len_d = f_sat8(rst_len_q);
    end else begin
      if (cmd_r == `DRI_CMD_MRS && state_q != ST_RESET) begin
        mr_we = 1'b1;
        if (mrs_gap_q < MRD_CYC)
          err_set[`DRI_ERR_TMRD] = 1'b1; // [R21]
      end
      if (state_q == ST_MRS || state_q == ST_ZQ || state_q == ST_CAL) begin
        if (!cke_r)
          err_set[`DRI_ERR_CKE_DROP] = 1'b1; // [R08]
        if (odt_r != odt_lock_q)
          err_set[`DRI_ERR_ODT] = 1'b1; // [R10]
      end
      case (state_q)
        ST_RESET: begin
          // no advance until the pin has been seen low since power-on
          if (rst_len_q != 8'h00) begin
            if (rst_len_q < `DRI_CYC_RST)
              err_set[`DRI_ERR_SHORT_RST] = 1'b1; // [R04]
            if (cke_r || cke_low_q < `DRI_CYC_CKE_LOW)
              err_set[`DRI_ERR_CKE_NOT_LOW] = 1'b1; // [R03]
            state_d = ST_INTINIT;
            cnt_d = 16'h0000;
            rst_len_d = 8'h00;
          end
        end
        ST_INTINIT: begin
          // internal init runs on our own clock, not on the link clock [R05]
          cnt_d = cnt_q + 16'h0001;
          if (cke_r)
            err_set[`DRI_ERR_EARLY_CKE] = 1'b1; // [R05]
          if (cnt_q >= INIT_CYC - 1)
            state_d = ST_WAIT_CKE;
        end
        ST_WAIT_CKE: begin
          if (cke_r) begin
            if (last_cmd_q != `DRI_CMD_NOP && last_cmd_q != `DRI_CMD_DES)
              err_set[`DRI_ERR_NO_NOP] = 1'b1; // [R07]
            state_d = ST_MRS;
            cnt_d = 16'h0000;
            step_d = 2'h0;
            cke_seen_d = 1'b1;
            odt_lock_d = odt_r; // [R10]
          end
        end
        ST_MRS: begin
          if (cnt_q != 16'hFFFF)
            cnt_d = cnt_q + 16'h0001;
          if (cmd_r == `DRI_CMD_MRS) begin
            if (cnt_q < XPR_CYC - 1)
              err_set[`DRI_ERR_TXPR] = 1'b1; // [R11]
            if (ba_r != f_exp_ba(step_q)) begin
              err_set[`DRI_ERR_ORDER] = 1'b1; // [R12]
            end else begin
              if (step_q == 2'h2) begin
                if (addr_r[`DRI_MR1_DLL_DIS])
                  err_set[`DRI_ERR_DLL] = 1'b1; // [R13]
                if (x16_q && addr_r[`DRI_MR1_TDQS])
                  err_set[`DRI_ERR_X16_TDQS] = 1'b1; // [R17]
                if ((addr_r[9] | addr_r[6] | addr_r[2]) && odt_lock_q)
                  err_set[`DRI_ERR_ODT] = 1'b1; // [R10]
              end
              if (step_q == 2'h3) begin
                if (!addr_r[`DRI_MR0_DLL_RST])
                  err_set[`DRI_ERR_DLL] = 1'b1; // [R14]
                state_d = ST_ZQ;
              end
              step_d = step_q + 2'h1; // [R12]
            end
          end else if (cmd_r == `DRI_CMD_ZQL || cmd_r == `DRI_CMD_OTHER) begin
            err_set[`DRI_ERR_ORDER] = 1'b1;
          end
        end
        ST_ZQ: begin
          if (cmd_r == `DRI_CMD_ZQL) begin
            if (mrs_gap_q < MOD_CYC)
              err_set[`DRI_ERR_TMOD] = 1'b1; // [R21]
            state_d = ST_CAL;
            cnt_d = 16'h0000;
          end else if (cmd_r == `DRI_CMD_OTHER) begin
            err_set[`DRI_ERR_ORDER] = 1'b1;
          end
        end
        ST_CAL: begin
          // one wait covers both DLL lock and initial calibration [R15]
          cnt_d = cnt_q + 16'h0001;
          if (cmd_r != `DRI_CMD_NOP && cmd_r != `DRI_CMD_DES)
            err_set[`DRI_ERR_ORDER] = 1'b1; // [R15]
          if (cnt_q >= CAL_CYC - 1)
            state_d = ST_READY;
        end
        ST_READY: begin
          state_d = ST_READY;
        end
        default: begin
          state_d = ST_RESET;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= ST_RESET;
      cnt_q <= 16'h0000;
      step_q <= 2'h0;
      rst_len_q <= 8'h00;
      cke_low_q <= 8'h00;
      mrs_gap_q <= 8'hFF;
      last_cmd_q <= `DRI_CMD_DES;
      cke_seen_q <= 1'b0;
      odt_lock_q <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        mr_q[i] <= 14'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      rst_len_q <= rst_len_d;
      cke_low_q <= cke_r ? 8'h00 : f_sat8(cke_low_q);
      mrs_gap_q <= mr_we ? 8'h01 : f_sat8(mrs_gap_q);
      last_cmd_q <= cmd_r;
      cke_seen_q <= cke_seen_d;
      odt_lock_q <= odt_lock_d;
      if (mr_we && ba_r[2] == 1'b0)
        mr_q[ba_r[1:0]] <= addr_r;
    end
  end

  // ODT termination stays off through reset and until CKE is registered high; TDQS termination follows only x16_q and MR1 A11 [R09]
  always @(posedge sys_clk) begin
    if (!nrst) begin
      odt_term_en <= 1'b0;
      tdqs_term_en <= 1'b0;
      dm_en <= 1'b1;
      init_done <= 1'b0;
      dqsl_o <= 1'b0;
      dqsl_n_o <= 1'b1;
      dqsl_oe <= 1'b0;
      dqsu_o <= 1'b0;
      dqsu_n_o <= 1'b1;
      dqsu_oe <= 1'b0;
    end else begin
      odt_term_en <= rst_r & cke_seen_q & odt_r & rtt_nom_on; // [R09]
      tdqs_term_en <= ~x16_q & mr_q[1][`DRI_MR1_TDQS]; // [R16]
      dm_en <= ~(~x16_q & mr_q[1][`DRI_MR1_TDQS]); // [R16]
      init_done <= (state_q == ST_READY);
      // strobe leaves on the same edge as read data, so it is edge-aligned [R18]
      dqsl_o <= rd_strobe;
      dqsl_n_o <= ~rd_strobe; // [R18]
      dqsl_oe <= rd_active & rst_r;
      // upper pair exists only on the wide part and times the upper byte [R19]
      dqsu_o <= rd_strobe;
      dqsu_n_o <= ~rd_strobe;
      dqsu_oe <= rd_active & rst_r & x16_q; // [R19]
    end
  end

  assign wr_acc = psel & penable & pwrite;
  assign mapped = (paddr == `DRI_OFF_CTRL) || (paddr == `DRI_OFF_STATUS) ||
                  (paddr == `DRI_OFF_ERR) || (paddr[7:4] == `DRI_OFF_MR_BASE &&
                  paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      x16_q <= `DRI_CTRL_RST;
      err_q <= {`DRI_ERR_W{1'b0}};
    end else begin
      if (wr_acc && paddr == `DRI_OFF_CTRL)
        x16_q <= pwdata[0];
      // a new error in the clearing cycle survives the clear
      if (wr_acc && paddr == `DRI_OFF_ERR)
        err_q <= (err_q & ~pwdata[`DRI_ERR_W-1:0]) | err_set;
      else
        err_q <= err_q | err_set;
    end
  end

  // read data is taken in the setup cycle so it comes from a flip-flop
  always @(posedge sys_clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
      if (paddr == `DRI_OFF_CTRL)
        prdata <= {31'h00000000, x16_q};
      else if (paddr == `DRI_OFF_STATUS)
        prdata <= {24'h000000, step_q, odt_lock_q, cke_seen_q, init_done, state_q};
      else if (paddr == `DRI_OFF_ERR)
        prdata <= {20'h00000, err_q};
      else if (paddr[7:4] == `DRI_OFF_MR_BASE && paddr[1:0] == 2'h0)
        prdata <= {18'h00000, mr_q[paddr[3:2]]};
    end
  end

endmodule // dri_top

// ### dri_top_sva.sv
// assertions on the tracker's top-level ports
`timescale 1ns/1ps
module dri_top_sva (
  input logic sys_clk,
  input logic nrst,
  input logic mem_reset_n,
  input logic mem_cke,
  input logic rd_active,
  input logic rd_strobe,
  input logic dqsl_o,
  input logic dqsl_n_o,
  input logic dqsl_oe,
  input logic dqsu_o,
  input logic dqsu_n_o,
  input logic dqsu_oe,
  input logic odt_term_en,
  input logic tdqs_term_en,
  input logic dm_en,
  input logic init_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // three samples cover the pin register and the output register
  sequence s_rst_held;
    !mem_reset_n [*3];
  endsequence
  property p_odt_off;
    s_rst_held |-> !odt_term_en;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("odt on in reset");
  property p_oe_off;
    s_rst_held |-> !dqsl_oe && !dqsu_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("strobe driven in reset");
  property p_done_drop;
    $fell(mem_reset_n) |-> ##[1:3] !init_done;
  endproperty
  a_done_drop: assert property (p_done_drop) else $error("ready kept in reset");
  property p_done_cke;
    $rose(init_done) |-> $past(mem_cke, 2) && $past(mem_reset_n, 2);
  endproperty
  a_done_cke: assert property (p_done_cke) else $error("ready without cke");
  property p_mask_excl;
    tdqs_term_en ^ dm_en;
  endproperty
  a_mask_excl: assert property (p_mask_excl) else $error("mask and tdqs clash");
  property p_diff;
    (dqsl_n_o == !dqsl_o) && (dqsu_n_o == !dqsu_o);
  endproperty
  a_diff: assert property (p_diff) else $error("strobe pair not complementary");
  property p_lat;
    $past(nrst) && $past(nrst, 2) |-> dqsl_o == $past(rd_strobe) && dqsu_o == $past(rd_strobe);
  endproperty
  a_lat: assert property (p_lat) else $error("strobe latency wrong");
  property p_upper;
    dqsu_oe |-> dqsl_oe && $past(rd_active);
  endproperty
  a_upper: assert property (p_upper) else $error("upper strobe alone");
endmodule // dri_top_sva
bind dri_top dri_top_sva dri_top_sva_inst (.sys_clk(sys_clk), .nrst(nrst),
  .mem_reset_n(mem_reset_n), .mem_cke(mem_cke), .rd_active(rd_active), .rd_strobe(rd_strobe),
  .dqsl_o(dqsl_o), .dqsl_n_o(dqsl_n_o), .dqsl_oe(dqsl_oe), .dqsu_o(dqsu_o),
  .dqsu_n_o(dqsu_n_o), .dqsu_oe(dqsu_oe), .odt_term_en(odt_term_en),
  .tdqs_term_en(tdqs_term_en), .dm_en(dm_en), .init_done(init_done));
